// File: verilog/mau_top.sv
`timescale 1ns/1ps
// Behaviour
// - the program counter spans 9 bits on the small variant and 10 bits otherwise, in a 1K-word space.
// - above 512 words a status bit selects the program page.
// - fetch addresses beyond the implemented memory wrap into it.
// - after reset fetch starts at address zero.
// - the indirect window has no storage and accesses go to the address in the pointer.
// - reading the window through itself returns zero.
// - writing the window through itself changes no memory.
// - the low five pointer bits select the address within a bank.
// - the small variant has no banking and pointer bits 7 to 5 read as ones.
// - the mid variant banks on pointer bit 5 and bits 7 and 6 read as ones.
// - the large variant banks on pointer bits 6 and 5 and bit 7 reads as one.
module mau_top
  import mau_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire mau_pkg::mau_variant_t variant,
  input  wire logic                 pc_advance,
  input  wire logic                 pc_load,
  input  wire logic [10:0]          pc_target,
  input  wire logic                 page_select,
  input  wire logic [4:0]           file_addr,
  input  wire logic                 data_wr,
  input  wire logic [7:0]           data_wdata,
  input  wire logic [7:0]           mem_rdata,
  output logic [10:0]               program_counter,
  output logic [10:0]               fetch_addr,
  output logic                      cal_word_hit,
  output logic [6:0]                mem_addr,
  output logic                      mem_we,
  output logic [7:0]                mem_wdata,
  output logic [7:0]                rdata,
  output logic [7:0]                file_select_pointer
);
  import mau_pkg::*;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [10:0] wrap_addr(input mau_variant_t v, input logic [10:0] a);
    logic [10:0] r;
    r = a & MAU_PMEM_MASK_MID;
    if (v == MAU_VAR_SMALL)
      r = a & MAU_PMEM_MASK_SMALL;
    return r;
  endfunction

  function automatic logic [7:0] fill_of(input mau_variant_t v);
    logic [7:0] f;
    f = MAU_FILL_LARGE;
    unique case (v)
      MAU_VAR_SMALL: f = MAU_FILL_SMALL;
      MAU_VAR_MID:   f = MAU_FILL_MID;
      default:       f = MAU_FILL_LARGE;
    endcase
    return f;
  endfunction

  // ----------------------------------------
  // data decode
  // ----------------------------------------
  mau_dbus_if dbus ();
  logic [7:0] ptr;
  assign dbus.pointer   = ptr | fill_of(variant);
  assign dbus.file_addr = file_addr;

  mau_data_decode u_decode
  (
    .variant (variant),
    .dbus    (dbus)
  );

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  logic [10:0] pc;
  logic [10:0] next_pc;
  logic [10:0] raw;
  always_comb
  begin
    raw = pc;
    if (pc_load)
    begin
      raw = pc_target;
      if (variant != MAU_VAR_SMALL)
        raw[MAU_PAGE_BIT] = page_select;
    end
    else if (pc_advance)
      raw = pc + 11'h001;
    next_pc = wrap_addr(variant, raw);
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      pc <= MAU_RESET_VECTOR;
    else
      pc <= next_pc;
  end

  // ----------------------------------------
  // pointer and data path
  // ----------------------------------------
  logic [7:0]  next_ptr;
  logic [6:0]  next_mem_addr;
  logic        next_mem_we;
  logic [7:0]  next_rdata;
  logic        ptr_direct_wr;
  always_comb
  begin
    ptr_direct_wr = data_wr && !dbus.window_hit && (file_addr == MAU_POINTER_ADDR);
    next_ptr      = ptr_direct_wr ? data_wdata : ptr;
    next_mem_addr = dbus.data_addr;
    next_mem_we   = data_wr && !dbus.self_ref && !ptr_direct_wr;
    if (dbus.self_ref)
      next_rdata = MAU_SELF_READ;
    else if (!dbus.window_hit && file_addr == MAU_POINTER_ADDR)
      next_rdata = dbus.pointer;
    else
      next_rdata = mem_rdata;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ptr                 <= MAU_POINTER_RESET;
      program_counter     <= MAU_RESET_VECTOR;
      fetch_addr          <= MAU_RESET_VECTOR;
      cal_word_hit        <= 1'b0;
      mem_addr            <= 7'h00;
      mem_we              <= 1'b0;
      mem_wdata           <= 8'h00;
      rdata               <= 8'h00;
      file_select_pointer <= MAU_POINTER_RESET;
    end
    else
    begin
      ptr                 <= next_ptr;
      program_counter     <= next_pc;
      fetch_addr          <= next_pc;
      cal_word_hit        <= (next_pc == ((variant == MAU_VAR_SMALL) ? MAU_CAL_WORD_SMALL
                                                                      : MAU_CAL_WORD_MID));
      mem_addr            <= next_mem_addr;
      mem_we              <= next_mem_we;
      mem_wdata           <= data_wdata;
      rdata               <= next_rdata;
      file_select_pointer <= next_ptr | fill_of(variant);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  pc_reset_a: assert property (@(posedge ref_clk) $fell(rst) |-> program_counter == 11'h000)
    else $error("pc not zero after reset");
  pc_wrap_a: assert property (@(posedge ref_clk) disable iff (rst)
    variant == MAU_VAR_SMALL |=> program_counter[10:9] == 2'h0)
    else $error("pc beyond small memory");
  pc_mid_a: assert property (@(posedge ref_clk) disable iff (rst)
    variant == MAU_VAR_MID |=> program_counter[10] == 1'b0)
    else $error("pc beyond mid memory");
  self_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    file_addr == 5'h00 && ptr[4:0] == 5'h00 |=> rdata == 8'h00)
    else $error("self read not zero");
  self_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    data_wr && file_addr == 5'h00 && ptr[4:0] == 5'h00 |=> !mem_we)
    else $error("self write reached memory");
  indirect_addr_a: assert property (@(posedge ref_clk) disable iff (rst)
    file_addr == 5'h00 |=> mem_addr[4:0] == $past(ptr[4:0]))
    else $error("indirect address wrong");
  small_fill_a: assert property (@(posedge ref_clk) disable iff (rst)
    variant == MAU_VAR_SMALL |=> file_select_pointer[7:5] == 3'h7 && mem_addr[6:5] == 2'h0)
    else $error("small pointer fill wrong");
  mid_bank_a: assert property (@(posedge ref_clk) disable iff (rst)
    variant == MAU_VAR_MID |=> file_select_pointer[7:6] == 2'h3 && mem_addr[6] == 1'b0)
    else $error("mid bank wrong");
  large_bank_a: assert property (@(posedge ref_clk) disable iff (rst)
    variant == MAU_VAR_LARGE && file_addr != 5'h00 |=> mem_addr[6:5] == $past(ptr[6:5]))
    else $error("large bank wrong");
  page_a: assert property (@(posedge ref_clk) disable iff (rst)
    pc_load && variant == MAU_VAR_MID |=> program_counter[9] == $past(page_select))
    else $error("page bit not applied");

  fetch_match_a: assert property (@(posedge ref_clk) disable iff (rst)
    fetch_addr == program_counter)
    else $error("fetch address differs from pc");
  cal_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    cal_word_hit == (program_counter == ((variant == MAU_VAR_SMALL) ? MAU_CAL_WORD_SMALL
                                                                    : MAU_CAL_WORD_MID)))
    else $error("calibration flag wrong");
  ptr_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    data_wr && file_addr == MAU_POINTER_ADDR |=> !mem_we)
    else $error("pointer write reached memory");
  wdata_path_a: assert property (@(posedge ref_clk) disable iff (rst)
    data_wr |=> mem_wdata == $past(data_wdata))
    else $error("write data not forwarded");
  ptr_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    file_addr == MAU_POINTER_ADDR |=> rdata == $past(dbus.pointer))
    else $error("pointer read wrong");

  cov_page_c:  cover property (@(posedge ref_clk) disable iff (rst)
    pc_load && page_select && variant != MAU_VAR_SMALL);
  cov_wrap_c:  cover property (@(posedge ref_clk) disable iff (rst) pc_advance && pc == 11'h1ff);
  cov_self_c:  cover property (@(posedge ref_clk) disable iff (rst) data_wr && dbus.self_ref);
  cov_ind_c:   cover property (@(posedge ref_clk) disable iff (rst) dbus.window_hit && !dbus.self_ref);
  cov_bank_c:  cover property (@(posedge ref_clk) disable iff (rst) variant == MAU_VAR_LARGE && ptr[6:5] == 2'h3);
endmodule

// File: verilog/mau_pkg.sv
package mau_pkg;

  // ----------------------------------------
  // variants
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    MAU_VAR_SMALL = 2'h0,
    MAU_VAR_MID   = 2'h1,
    MAU_VAR_LARGE = 2'h2
  } mau_variant_t;

  // ----------------------------------------
  // program space
  // ----------------------------------------
  localparam int          MAU_PC_W         = 11;
  localparam int          MAU_PC_W_SMALL   = 10;
  localparam logic [10:0] MAU_RESET_VECTOR = 11'h000;
  localparam logic [10:0] MAU_PMEM_MASK_SMALL = 11'h1ff;
  localparam logic [10:0] MAU_PMEM_MASK_MID   = 11'h3ff;
  localparam logic [10:0] MAU_CAL_WORD_SMALL  = 11'h1ff;
  localparam logic [10:0] MAU_CAL_WORD_MID    = 11'h3ff;
  localparam int          MAU_PAGE_BIT     = 9;
  localparam int          MAU_STATUS_PAGE_BIT = 5;

  // ----------------------------------------
  // data space
  // ----------------------------------------
  localparam int          MAU_DADDR_W      = 7;
  localparam int          MAU_FILE_W       = 5;
  localparam logic [4:0]  MAU_WINDOW_ADDR  = 5'h00;
  localparam logic [4:0]  MAU_POINTER_ADDR = 5'h04;
  localparam logic [7:0]  MAU_POINTER_RESET = 8'he0;
  localparam logic [7:0]  MAU_FILL_SMALL   = 8'he0;
  localparam logic [7:0]  MAU_FILL_MID     = 8'hc0;
  localparam logic [7:0]  MAU_FILL_LARGE   = 8'h80;
  localparam logic [7:0]  MAU_SELF_READ    = 8'h00;

endpackage

// File: verilog/mau_dbus_if.sv
`timescale 1ns/1ps
interface mau_dbus_if;
  import mau_pkg::*;
  logic [7:0] pointer;
  logic [4:0] file_addr;
  logic [6:0] data_addr;
  logic       window_hit;
  logic       self_ref;

  modport top
  (
    output pointer,
    output file_addr,
    input  data_addr,
    input  window_hit,
    input  self_ref
  );
  modport decode
  (
    input  pointer,
    input  file_addr,
    output data_addr,
    output window_hit,
    output self_ref
  );
endinterface

// File: verilog/mau_data_decode.sv
`timescale 1ns/1ps
module mau_data_decode
  import mau_pkg::*;
(
  input  mau_pkg::mau_variant_t variant,
  mau_dbus_if.decode            dbus
);
  import mau_pkg::*;

  // ----------------------------------------
  // bank bits per variant
  // ----------------------------------------
  function automatic logic [1:0] bank_of(input mau_variant_t v, input logic [7:0] p);
    logic [1:0] b;
    b = 2'h0;
    unique case (v)
      MAU_VAR_SMALL: b = 2'h0;
      MAU_VAR_MID:   b = {1'b0, p[5]};
      MAU_VAR_LARGE: b = p[6:5];
      default:       b = 2'h0;
    endcase
    return b;
  endfunction

  logic       indirect;
  logic [4:0] low;
  always_comb
  begin
    indirect        = (dbus.file_addr == MAU_WINDOW_ADDR);
    low             = indirect ? dbus.pointer[4:0] : dbus.file_addr;
    dbus.data_addr  = {bank_of(variant, dbus.pointer), low};
    dbus.window_hit = indirect;
    dbus.self_ref   = indirect && (dbus.pointer[4:0] == MAU_WINDOW_ADDR);
  end
endmodule

// File: tb/mau_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// data memory beside the addressing unit
// ----------------------------------------
module mau_mem_model
(
  input  wire logic       ref_clk,
  input  wire logic       mem_we,
  input  wire logic [6:0] mem_addr,
  input  wire logic [7:0] mem_wdata,
  input  wire logic [6:0] rd_addr,
  output logic [7:0]      rd_data
);
  logic [7:0] mem [128];

  initial
  begin
    for (int i = 0; i < 128; i++)
      mem[i] = 8'h5a ^ 8'(i);
  end

  // storage lives here, the window only redirects
  always @(posedge ref_clk)
    if (mem_we === 1'b1)
      mem[mem_addr] <= mem_wdata;

  assign rd_data = mem[rd_addr];
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import mau_pkg::*;
  typedef struct {mau_variant_t v; logic [7:0] w, p; logic [6:0] ia, da;} mau_row_t;
  logic ref_clk = 1'b0, rst = 1'b1, pc_advance = 1'b0, pc_load = 1'b0, page_select = 1'b0, data_wr = 1'b0;
  logic [10:0] pc_target = 11'h000, program_counter, fetch_addr;
  logic [4:0] file_addr = 5'h00;
  logic [7:0] data_wdata = 8'h00, mem_rdata, mem_wdata, rdata, file_select_pointer, wv;
  logic [6:0] mem_addr, rd_addr = 7'h00;
  logic cal_word_hit, mem_we;
  mau_variant_t variant = MAU_VAR_SMALL;
  int n_fail = 0, cmp_count = 0, cyc = 0;
  mau_row_t rows [6] = '{
    '{MAU_VAR_SMALL, 8'h3a, 8'hfa, 7'h1a, 7'h11}, '{MAU_VAR_MID, 8'h3a, 8'hfa, 7'h3a, 7'h31},
    '{MAU_VAR_LARGE, 8'h3a, 8'hba, 7'h3a, 7'h31}, '{MAU_VAR_SMALL, 8'h47, 8'he7, 7'h07, 7'h11},
    '{MAU_VAR_MID, 8'h47, 8'hc7, 7'h07, 7'h11}, '{MAU_VAR_LARGE, 8'h47, 8'hc7, 7'h47, 7'h51}};

  always #12.5 ref_clk = ~ref_clk;

  mau_top dut (.ref_clk(ref_clk), .rst(rst), .variant(variant), .pc_advance(pc_advance), .pc_load(pc_load),
    .pc_target(pc_target), .page_select(page_select), .file_addr(file_addr), .data_wr(data_wr),
    .data_wdata(data_wdata), .mem_rdata(mem_rdata), .program_counter(program_counter),
    .fetch_addr(fetch_addr), .cal_word_hit(cal_word_hit), .mem_addr(mem_addr), .mem_we(mem_we),
    .mem_wdata(mem_wdata), .rdata(rdata), .file_select_pointer(file_select_pointer));

  mau_mem_model mem (.ref_clk(ref_clk), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .rd_addr(rd_addr), .rd_data(mem_rdata));

  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rst_to(input mau_variant_t v);
    @(posedge ref_clk);
    variant <= v;
    rst     <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
  endtask

  task automatic op(input logic [4:0] fa, input logic wr, input logic [7:0] wd, input logic [6:0] ra);
    @(posedge ref_clk);
    file_addr  <= fa;
    data_wr    <= wr;
    data_wdata <= wd;
    rd_addr    <= ra;
    @(posedge ref_clk);
    data_wr <= 1'b0;
    #1;
  endtask

  task automatic pcop(input logic ld, adv, input logic [10:0] tgt, input logic pg, input logic [10:0] ep,
                      input logic ec);
    @(posedge ref_clk);
    pc_load     <= ld;
    pc_advance  <= adv;
    pc_target   <= tgt;
    page_select <= pg;
    @(posedge ref_clk);
    pc_load    <= 1'b0;
    pc_advance <= 1'b0;
    #1;
    chk(program_counter, ep);
    chk(fetch_addr, ep);
    chk(11'(cal_word_hit), 11'(ec));
  endtask

  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_fail++;
      end_sim();
    end
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    #1;
    chk(program_counter, MAU_RESET_VECTOR);
    pcop(1'b1, 1'b0, 11'h3ff, 1'b0, 11'h1ff, 1'b1);
    pcop(1'b0, 1'b1, 11'h000, 1'b0, 11'h000, 1'b0);
    rst_to(MAU_VAR_MID);
    pcop(1'b1, 1'b0, 11'h1f0, 1'b1, 11'h3f0, 1'b0);
    pcop(1'b1, 1'b0, 11'h7ff, 1'b1, 11'h3ff, 1'b1);
    pcop(0, 1'b1, 11'h000, 1'b0, 11'h000, 1'b0);
    rst_to(MAU_VAR_LARGE);
    pcop(1'b1, 1'b0, 11'h5fe, 1'b0, 11'h1fe, 1'b0);
    foreach (rows[i])
    begin
      rst_to(rows[i].v);
      wv = rows[i].w ^ 8'h99;
      chk(program_counter, MAU_RESET_VECTOR);
      chk(file_select_pointer, MAU_POINTER_RESET);
      op(MAU_POINTER_ADDR, 1'b1, rows[i].w, rows[i].ia);
      chk(file_select_pointer, rows[i].p);
      chk(mem_we, 1'b0);
      op(MAU_WINDOW_ADDR, 1'b1, wv, rows[i].ia);
      chk(mem_we, 1'b1);
      chk(mem_addr, rows[i].ia);
      chk(mem_wdata, wv);
      op(MAU_WINDOW_ADDR, 1'b0, 8'h00, rows[i].ia);
      chk(rdata, wv);
      op(5'h11, 1'b0, 8'h00, rows[i].da);
      chk(mem_addr, rows[i].da);
    end
    op(MAU_POINTER_ADDR, 1'b1, 8'h00, 7'h00);
    chk(file_select_pointer, MAU_FILL_LARGE);
    op(MAU_WINDOW_ADDR, 1'b0, 8'h00, 7'h00);
    chk(rdata, MAU_SELF_READ);
    op(MAU_WINDOW_ADDR, 1'b1, 8'h77, 7'h00);
    chk(mem_we, 1'b0);
    end_sim();
  end
endmodule
